// File: hdl/ecgfr_pkg.sv
// Behaviour
// RULE1 - Samples are 18-bit two's complement, left-justified.
// RULE2 - Host selects gain 20, 40, 80 or 160.
// RULE3 - Two-bit field selects automatic or manual recovery.
// RULE4 - Saturation timer starts and accumulates beyond threshold.
// RULE5 - After 125 ms over: trigger settling, clear timer.
// RULE6 - 125 ms continuously inside clears timer, no trigger.
// RULE7 - Automatic fast settling stays active 500 ms.
// RULE8 - Settling length in samples follows rate table.
// RULE9 - Samples taken during settling carry a tag.
// RULE10 - Manual mode: host switches fast recovery itself.
// RULE11 - FIR decimation, then IIR high-pass, FIR low-pass.
// RULE12 - High-pass: first-order 0.4 Hz IIR or bypass.
// RULE13 - Low-pass: 12-tap linear-phase FIR, three corners.
// RULE14 - Decimation ratios 64, 128, 160, 256 supported.
// RULE15 - Latency per ratio, with and without low-pass.
// RULE16 - Tag travels as flag inside each sample word.
package ecgfr_pkg;

  localparam logic [7:0] A_STAT = 8'h02;
  localparam logic [7:0] A_LAT = 8'h03;
  localparam logic [7:0] A_DYN = 8'h05;
  localparam logic [7:0] A_ECG = 8'h15;
  localparam logic [7:0] A_SAMP = 8'h21;

  localparam int DYN_MODE_LSB = 22;
  localparam int DYN_THR_LSB = 16;
  localparam int ECG_RATIO_LSB = 22;
  localparam int CHANNEL_GAIN_SEL_LSB = 16;
  localparam int ECG_HPF_BIT = 14;
  localparam int ECG_LPF_LSB = 12;
  localparam int ECG_RATE_BIT = 0;
  localparam int STAT_OVF_BIT = 2;
  localparam int WORD_TAG_BIT = 5;

  localparam logic [23:0] DYN_RST = 24'h000000;
  localparam logic [23:0] ECG_RST = 24'h000000;

  localparam int CLK_HZ = 20_000_000;
  localparam int T_SAT_MS = 125;
  localparam int T_BLW_MS = 125;
  localparam int T_SAT_CYC = T_SAT_MS * (CLK_HZ / 1000);
  localparam int T_BLW_CYC = T_BLW_MS * (CLK_HZ / 1000);

  typedef enum logic [1:0] {
    FAST_OFF = 2'h0,
    FAST_MAN = 2'h1,
    FAST_AUTO = 2'h2
  } ecgfr_fast_t;

  typedef enum logic [1:0] {
    SAT_IDLE = 2'h0,
    SAT_RUN = 2'h1,
    SAT_HOLD = 2'h3
  } ecgfr_sat_t;

  function automatic logic [8:0] dec_len(input logic [1:0] r);
    case (r)
      2'h0: dec_len = 9'h040;
      2'h1: dec_len = 9'h080;
      2'h2: dec_len = 9'h0a0;
      default: dec_len = 9'h100;
    endcase
  endfunction

  // Ratio 160 is not a power of two, so it scales by 205/32768.
  function automatic logic [8:0] dec_mul(input logic [1:0] r);
    dec_mul = (r == 2'h2) ? 9'h0cd : 9'h001;
  endfunction

  function automatic logic [4:0] dec_sh(input logic [1:0] r);
    case (r)
      2'h0: dec_sh = 5'h06;
      2'h1: dec_sh = 5'h07;
      2'h2: dec_sh = 5'h0f;
      default: dec_sh = 5'h08;
    endcase
  endfunction

  // Pole shift keeps the corner near 0.4 Hz at each output rate.
  function automatic logic [3:0] hp_sh(input logic [1:0] r);
    case (r)
      2'h0: hp_sh = 4'h8;
      2'h1: hp_sh = 4'h7;
      default: hp_sh = 4'h6;
    endcase
  endfunction

  function automatic logic [7:0] settle_len(input logic [1:0] r, input logic k32000);
    case (r)
      2'h0: settle_len = k32000 ? 8'hf9 : 8'hff;
      2'h1: settle_len = k32000 ? 8'h7c : 8'h7f;
      2'h2: settle_len = 8'h63;
      default: settle_len = k32000 ? 8'h40 : 8'h3f;
    endcase
  endfunction

  function automatic logic [12:0] lat_in(input logic [1:0] r, input logic lp);
    case (r)
      2'h0: lat_in = lp ? 13'h040a : 13'h028a;
      2'h1: lat_in = lp ? 13'h0e6a : 13'h0b6a;
      2'h2: lat_in = lp ? 13'h089a : 13'h04da;
      default: lat_in = lp ? 13'h132a : 13'h0d2a;
    endcase
  endfunction

  // Symmetric taps, each half sums to 64, so the gain is 128.
  function automatic logic signed [7:0] lpf_coef(input logic [1:0] sel, input logic [3:0] i);
    logic [3:0] j;
    j = (i < 4'h6) ? i : 4'hb - i;
    case ({sel, j[2:0]})
      5'h08: lpf_coef = 8'sh02;
      5'h09: lpf_coef = 8'sh04;
      5'h0a: lpf_coef = 8'sh07;
      5'h0b: lpf_coef = 8'sh0b;
      5'h0c: lpf_coef = 8'sh10;
      5'h0d: lpf_coef = 8'sh18;
      5'h10: lpf_coef = -8'sh01;
      5'h12: lpf_coef = 8'sh04;
      5'h13: lpf_coef = 8'sh0c;
      5'h14: lpf_coef = 8'sh15;
      5'h15: lpf_coef = 8'sh1c;
      5'h18: lpf_coef = -8'sh02;
      5'h19: lpf_coef = -8'sh03;
      5'h1a: lpf_coef = 8'sh02;
      5'h1b: lpf_coef = 8'sh0d;
      5'h1c: lpf_coef = 8'sh18;
      5'h1d: lpf_coef = 8'sh1e;
      default: lpf_coef = 8'sh00;
    endcase
  endfunction

  function automatic logic signed [17:0] sat18(input logic signed [31:0] v);
    if (v > 32'sh0001ffff) begin
      sat18 = 18'sh1ffff;
    end else if (v < -32'sh00020000) begin
      sat18 = -18'sh20000;
    end else begin
      sat18 = v[17:0];
    end
  endfunction

endpackage

// File: hdl/ecgfr_top.sv
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
module ecgfr_fifo #(
  parameter int W = 24,
  parameter int D = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);

  // Pointers carry one extra bit so that full and empty differ.
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } ecgfr_fifo_st_t;

  ecgfr_fifo_st_t s;
  ecgfr_fifo_st_t n;
  logic full;
  logic empty;

  always_comb begin
    n = s;
    full = (s.wp[AW] != s.rp[AW]) && (s.wp[AW-1:0] == s.rp[AW-1:0]);
    empty = (s.wp == s.rp);
    in_ready = !full;
    out_valid = !empty;
    out_data = s.mem[s.rp[AW-1:0]];
    if (in_valid && !full) begin
      n.mem[s.wp[AW-1:0]] = in_data;
      n.wp = s.wp + 1'b1;
    end
    if (out_ready && !empty) begin
      n.rp = s.rp + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
endmodule

module ecgfr_top #(
  parameter int SAT_CYC = ecgfr_pkg::T_SAT_CYC,
  parameter int BLW_CYC = ecgfr_pkg::T_BLW_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic mod_vld,
  input wire logic [17:0] mod_data,
  input wire logic [7:0] addr,
  input wire logic [23:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [23:0] rdata,
  output logic fast_settle,
  output logic [1:0] channel_gain_sel
);
  localparam logic [21:0] SAT_LIM = 22'(SAT_CYC - 1);
  localparam logic [21:0] BLW_LIM = 22'(BLW_CYC - 1);

  typedef struct packed {
    logic [23:0] dyn;
    logic [23:0] ecg;
    logic signed [25:0] acc;
    logic [8:0] dcnt;
    logic over;
    ecgfr_pkg::ecgfr_sat_t st;
    logic [21:0] scnt;
    logic [21:0] bcnt;
    logic [7:0] settle;
    logic fast;
    logic signed [17:0] hx;
    logic signed [23:0] hy;
    logic [11:0][17:0] taps;
    logic st1;
    logic tag1;
    logic [23:0] word;
    logic pend;
    logic ovf;
    logic [23:0] rdata;
  } ecgfr_state_t;

  ecgfr_state_t s;
  ecgfr_state_t n;
  logic [1:0] ratio;
  ecgfr_pkg::ecgfr_fast_t mode;
  logic [5:0] thr;
  logic signed [17:0] tv;
  logic [8:0] dlen;
  logic [7:0] slen;
  logic [1:0] lsel;
  logic hpf_on;
  logic dec_done;
  logic signed [25:0] dsum;
  logic signed [35:0] prod;
  logic signed [17:0] dval;
  logic signed [23:0] hy_new;
  logic signed [17:0] hp_out;
  logic signed [30:0] lsum;
  logic signed [17:0] lp_out;
  logic pop;
  logic f_ready;
  logic f_ovalid;
  logic [23:0] f_odata;

  ecgfr_fifo #(
    .W(24),
    .D(8)
  ) u_fifo (
    .clk(clk),
    .srst(srst),
    .in_valid(s.pend),
    .in_ready(f_ready),
    .in_data(s.word),
    .out_valid(f_ovalid),
    .out_ready(pop),
    .out_data(f_odata)
  );

  always_comb begin
    n = s;
    pop = 1'b0;
    ratio = s.ecg[ecgfr_pkg::ECG_RATIO_LSB +: 2];
    mode = ecgfr_pkg::ecgfr_fast_t'(s.dyn[ecgfr_pkg::DYN_MODE_LSB +: 2]); // [RULE3]
    thr = s.dyn[ecgfr_pkg::DYN_THR_LSB +: 6];
    tv = $signed({1'b0, thr, 11'h000}); // [RULE4]
    dlen = ecgfr_pkg::dec_len(ratio); // [RULE14]
    slen = ecgfr_pkg::settle_len(ratio, s.ecg[ecgfr_pkg::ECG_RATE_BIT]); // [RULE8] [RULE7]
    lsel = s.ecg[ecgfr_pkg::ECG_LPF_LSB +: 2];
    hpf_on = s.ecg[ecgfr_pkg::ECG_HPF_BIT];

    if (wr && addr == ecgfr_pkg::A_DYN) begin
      n.dyn = wdata;
    end
    if (wr && addr == ecgfr_pkg::A_ECG) begin
      n.ecg = wdata; // [RULE2]
    end

    // Boxcar FIR decimation, rescaled back to full 18-bit range.
    dsum = s.acc + 26'($signed(mod_data));
    dec_done = mod_vld && (s.dcnt == dlen - 9'h001); // [RULE11]
    prod = 36'(dsum) * 36'($signed({1'b0, ecgfr_pkg::dec_mul(ratio)}));
    dval = ecgfr_pkg::sat18(32'(prod >>> ecgfr_pkg::dec_sh(ratio)));
    if (mod_vld) begin
      if (dec_done) begin
        n.acc = 26'sh0;
        n.dcnt = 9'h000;
      end else begin
        n.acc = dsum;
        n.dcnt = s.dcnt + 9'h001;
      end
    end

    // Integer pole keeps this cheap; a small DC bias from truncation remains.
    hy_new = 24'(dval) - 24'(s.hx) + s.hy - (s.hy >>> ecgfr_pkg::hp_sh(ratio)); // [RULE12]
    hp_out = hpf_on ? ecgfr_pkg::sat18(32'(hy_new)) : dval; // [RULE12]
    n.st1 = dec_done;
    if (dec_done) begin
      n.over = (dval > tv) || (dval < -tv); // [RULE4]
      n.tag1 = s.fast; // [RULE9]
      n.hx = dval;
      n.hy = hpf_on ? hy_new : 24'sh0;
      n.taps = {s.taps[10:0], hp_out}; // [RULE11]
    end

    lsum = 31'sh0;
    for (int i = 0; i < 12; i++) begin
      lsum = lsum + 31'(ecgfr_pkg::lpf_coef(lsel, 4'(i))) * 31'($signed(s.taps[i])); // [RULE13]
    end
    lp_out = (lsel == 2'h0) ? $signed(s.taps[0]) : ecgfr_pkg::sat18(32'(lsum >>> 7));

    // Output stage waits on the FIFO; a sample arriving while it waits overwrites the waiting one, which is lost.
    if (wr && addr == ecgfr_pkg::A_STAT && wdata[ecgfr_pkg::STAT_OVF_BIT]) begin
      n.ovf = 1'b0;
    end
    if (s.pend && f_ready) begin
      n.pend = 1'b0;
    end
    if (s.st1) begin
      if (s.pend && !f_ready) begin
        n.ovf = 1'b1;
      end
      n.word = {lp_out, s.tag1, 5'h00}; // [RULE1] [RULE16]
      n.pend = 1'b1;
    end

    if (dec_done && s.settle != 8'h00) begin
      n.settle = s.settle - 8'h01; // [RULE8]
    end
    case (s.st)
      ecgfr_pkg::SAT_IDLE: begin
        if (s.over) begin
          n.st = ecgfr_pkg::SAT_RUN; // [RULE4]
          n.scnt = 22'h000000;
          n.bcnt = 22'h000000;
        end
      end
      ecgfr_pkg::SAT_RUN: begin
        if (s.scnt == SAT_LIM) begin
          n.scnt = 22'h000000; // [RULE5]
          n.bcnt = 22'h000000;
          if (mode == ecgfr_pkg::FAST_AUTO) begin
            n.st = ecgfr_pkg::SAT_HOLD;
            n.settle = slen; // [RULE5] [RULE7]
          end else begin
            n.st = ecgfr_pkg::SAT_IDLE;
          end
        end else if (!s.over && s.bcnt == BLW_LIM) begin
          n.st = ecgfr_pkg::SAT_IDLE; // [RULE6]
          n.scnt = 22'h000000;
          n.bcnt = 22'h000000;
        end else if (s.over) begin
          n.scnt = s.scnt + 22'h000001; // [RULE4]
          n.bcnt = 22'h000000;
        end else begin
          n.bcnt = s.bcnt + 22'h000001;
        end
      end
      ecgfr_pkg::SAT_HOLD: begin
        if (s.settle == 8'h00) begin
          n.st = ecgfr_pkg::SAT_IDLE;
        end
      end
      default: begin
        n.st = ecgfr_pkg::SAT_IDLE;
      end
    endcase
    n.fast = (mode == ecgfr_pkg::FAST_MAN) || (n.settle != 8'h00); // [RULE3] [RULE10]

    n.rdata = 24'h000000;
    if (rd) begin
      case (addr)
        ecgfr_pkg::A_DYN: n.rdata = s.dyn;
        ecgfr_pkg::A_ECG: n.rdata = s.ecg;
        ecgfr_pkg::A_STAT: n.rdata = {19'h00000, s.st, s.ovf, f_ovalid, s.fast};
        ecgfr_pkg::A_LAT: n.rdata = {11'h000, ecgfr_pkg::lat_in(ratio, lsel != 2'h0)}; // [RULE15]
        ecgfr_pkg::A_SAMP: begin
          n.rdata = f_ovalid ? f_odata : 24'h000000;
          pop = f_ovalid;
        end
        default: n.rdata = 24'h000000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s <= '0;
      s.dyn <= ecgfr_pkg::DYN_RST;
      s.ecg <= ecgfr_pkg::ECG_RST;
    end else begin
      s <= n;
    end
  end

  assign rdata = s.rdata;
  assign fast_settle = s.fast;
  assign channel_gain_sel = s.ecg[ecgfr_pkg::CHANNEL_GAIN_SEL_LSB +: 2];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  a_sat_start: assert property ( // [RULE4]
    (s.st == ecgfr_pkg::SAT_IDLE && s.over) |=> (s.st == ecgfr_pkg::SAT_RUN && s.scnt == 22'h0)
  ) else $error("saturation timer did not start");

  a_auto_trigger: assert property ( // [RULE5]
    (s.st == ecgfr_pkg::SAT_RUN && s.scnt == SAT_LIM && mode == ecgfr_pkg::FAST_AUTO)
    |=> (s.st == ecgfr_pkg::SAT_HOLD && s.settle == $past(slen) && s.fast && s.scnt == 22'h0)
  ) else $error("automatic trigger did not load settling");

  a_below_clear: assert property ( // [RULE6]
    (s.st == ecgfr_pkg::SAT_RUN && !s.over && s.bcnt == BLW_LIM && s.scnt != SAT_LIM)
    |=> (s.st == ecgfr_pkg::SAT_IDLE && s.scnt == 22'h0 && s.settle == $past(n.settle))
  ) else $error("below-threshold window did not clear timer");

  a_manual_fast: assert property ( // [RULE3]
    (mode == ecgfr_pkg::FAST_MAN) |=> s.fast
  ) else $error("manual mode did not hold fast recovery");

  a_settle_ends: assert property ( // [RULE7]
    (mode != ecgfr_pkg::FAST_MAN && s.settle == 8'h01 && dec_done) |=> !s.fast
  ) else $error("fast settling did not end after its samples");

  a_tag_word: assert property ( // [RULE9]
    s.st1 |=> (s.pend && s.word[ecgfr_pkg::WORD_TAG_BIT] == $past(s.tag1))
  ) else $error("sample word lost its settling tag");

  a_left_justify: assert property ( // [RULE1]
    s.pend |-> (s.word[4:0] == 5'h00)
  ) else $error("sample word not left-justified");

  a_gain_pin: assert property ( // [RULE2]
    (wr && addr == ecgfr_pkg::A_ECG) |=> (channel_gain_sel == $past(wdata[17:16]))
  ) else $error("gain select did not follow register write");

  a_dec_ratio: assert property ( // [RULE14]
    (mod_vld && s.dcnt == dlen - 9'h001) |=> (s.st1 && s.dcnt == 9'h000) ##1 !s.st1
  ) else $error("decimator did not dump at ratio");

  a_ovf_sticky: assert property ( // [RULE16]
    (s.ovf && !(wr && addr == ecgfr_pkg::A_STAT && wdata[ecgfr_pkg::STAT_OVF_BIT])) |=> s.ovf
  ) else $error("overflow flag dropped without a clear");

  a_lat_read: assert property ( // [RULE15]
    (rd && addr == ecgfr_pkg::A_LAT) |=> (rdata[12:0] == $past(ecgfr_pkg::lat_in(ratio, lsel != 2'h0)))
  ) else $error("latency read gave wrong value");

  a_hold_fast: assert property ( // [RULE7]
    (s.st == ecgfr_pkg::SAT_HOLD && s.settle != 8'h00) |-> s.fast
  ) else $error("fast settling dropped while settling");

  a_settle_step: assert property ( // [RULE8]
    (s.st == ecgfr_pkg::SAT_HOLD && dec_done && s.settle != 8'h00)
    |=> (s.settle == $past(s.settle) - 8'h01)
  ) else $error("settling count did not step per sample");

  a_scnt_hold: assert property ( // [RULE4]
    (s.st == ecgfr_pkg::SAT_RUN && !s.over && s.scnt != SAT_LIM && s.bcnt != BLW_LIM)
    |=> (s.scnt == $past(s.scnt))
  ) else $error("saturation time lost during a quiet stretch");

  a_scnt_count: assert property ( // [RULE4]
    (s.st == ecgfr_pkg::SAT_RUN && s.over && s.scnt != SAT_LIM)
    |=> (s.scnt == $past(s.scnt) + 22'h000001)
  ) else $error("saturation time did not accumulate");

  a_hpf_bypass: assert property ( // [RULE12]
    (dec_done && !hpf_on) |=> (s.taps[0] == $past(dval))
  ) else $error("high-pass bypass altered the sample");

  a_lpf_bypass: assert property ( // [RULE13]
    (s.st1 && lsel == 2'h0) |=> (s.word[23:6] == $past(s.taps[0]))
  ) else $error("low-pass bypass altered the sample");

  a_sample_tag: assert property ( // [RULE9]
    dec_done |=> (s.tag1 == $past(s.fast))
  ) else $error("sample tag did not follow fast settling");

  a_gain_stable: assert property ( // [RULE2]
    !(wr && addr == ecgfr_pkg::A_ECG) |=> $stable(channel_gain_sel)
  ) else $error("gain select changed without a write");
endmodule

// File: tb/ecg_fast_recovery_decimation_tb.sv
`timescale 1ns/1ps
module ecg_fast_recovery_decimation_tb;
  localparam logic [17:0] HI = 18'h10000;
  localparam logic [23:0] MAN = 24'h400000;
  localparam logic [23:0] AUTO = 24'h810000;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic mod_vld = 1'b0;
  logic [17:0] mod_data = 18'h00000;
  logic [7:0] addr;
  logic [23:0] wdata, rdata, rv;
  logic wr, rd, fast_settle;
  logic fs_seen = 1'b0;
  logic [1:0] gain;
  int errors = 0;
  int checks_done = 0;
  int n;

  always #25 clk = ~clk;

  ecgfr_top #(.SAT_CYC(200), .BLW_CYC(50)) DUT (
    .clk(clk), .srst(srst), .mod_vld(mod_vld), .mod_data(mod_data),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .fast_settle(fast_settle), .channel_gain_sel(gain)
  );

  ecgfr_host u_host (
    .clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata)
  );

  always @(posedge clk) begin
    if (fast_settle === 1'b1) begin
      fs_seen <= 1'b1;
    end
  end

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  task automatic feed(input int cnt, input logic [17:0] v);
    repeat (cnt) begin
      @(posedge clk);
      mod_vld <= 1'b1;
      mod_data <= v;
    end
    @(posedge clk);
    mod_vld <= 1'b0;
    mod_data <= ~v;
  endtask

  task automatic t_regs();
    u_host.rd_reg(ecgfr_pkg::A_DYN, rv);
    check(rv, ecgfr_pkg::DYN_RST);
    u_host.rd_reg(ecgfr_pkg::A_ECG, rv);
    check(rv, ecgfr_pkg::ECG_RST);
    u_host.wr_reg(8'h7f, 24'hffffff);
    u_host.rd_reg(8'h7f, rv);
    check(rv, 24'h000000);
    for (int g = 0; g < 4; g++) begin
      u_host.wr_reg(ecgfr_pkg::A_ECG, 24'(g) << ecgfr_pkg::CHANNEL_GAIN_SEL_LSB);
      tick(2);
      check({22'h000000, gain}, 24'(g));
      u_host.rd_reg(ecgfr_pkg::A_ECG, rv);
      check(rv, 24'(g) << ecgfr_pkg::CHANNEL_GAIN_SEL_LSB);
    end
  endtask

  task automatic t_latency();
    int lat [8] = '{650, 1034, 2922, 3690, 1242, 2202, 3370, 4906};
    for (int i = 0; i < 8; i++) begin
      u_host.wr_reg(ecgfr_pkg::A_ECG, {i[2:1], 8'h00, i[0] ? 2'h1 : 2'h0, 12'h000});
      u_host.rd_reg(ecgfr_pkg::A_LAT, rv);
      check({11'h000, rv[12:0]}, 24'(lat[i]));
    end
  endtask

  task automatic t_sample();
    u_host.wr_reg(ecgfr_pkg::A_ECG, 24'h000000);
    feed(64, 18'h12345);
    tick(5);
    u_host.rd_reg(ecgfr_pkg::A_SAMP, rv);
    check(rv, {18'h12345, 1'b0, 5'h00});
  endtask

  task automatic t_manual();
    u_host.wr_reg(ecgfr_pkg::A_DYN, MAN);
    tick(2);
    check({23'h000000, fast_settle}, 24'h000001);
    feed(64, 18'h3ff00);
    tick(5);
    u_host.rd_reg(ecgfr_pkg::A_SAMP, rv);
    check(rv, {18'h3ff00, 1'b1, 5'h00});
    u_host.wr_reg(ecgfr_pkg::A_DYN, 24'h000000);
    tick(2);
    check({23'h000000, fast_settle}, 24'h000000);
  endtask

  // Over-threshold stretches of about 65 cycles, each followed by an equally long quiet
  // stretch, add up past the saturation limit only if the quiet time fails to clear.
  task automatic t_no_trigger();
    feed(64, 18'h00000);
    tick(60);
    u_host.wr_reg(ecgfr_pkg::A_DYN, AUTO);
    fs_seen = 1'b0;
    repeat (4) begin
      feed(64, HI);
      feed(64, 18'h00000);
    end
    tick(60);
    check({23'h000000, fs_seen}, 24'h000000);
    u_host.rd_reg(ecgfr_pkg::A_STAT, rv);
    check({22'h000000, rv[4:3]}, 24'h000000);
  endtask

  task automatic t_auto();
    feed(64, HI);
    tick(250);
    check({23'h000000, fast_settle}, 24'h000001);
    n = 0;
    while (fast_settle === 1'b1 && n < 300) begin
      feed(64, 18'h00000);
      tick(4);
      n++;
    end
    check(24'(n), 24'd255);
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    conclude();
  end

  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_latency();
    t_sample();
    t_manual();
    t_no_trigger();
    t_auto();
    conclude();
  end
endmodule

// File: tb/ecgfr_host.sv
`timescale 1ns/1ps
module ecgfr_host (
  input wire logic clk,
  output logic [7:0] addr,
  output logic [23:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [23:0] rdata
);
  initial begin
    addr = 8'h00;
    wdata = 24'h000000;
    wr = 1'b0;
    rd = 1'b0;
  end

  // Manual recovery is entered only through a write from this side.
  task automatic wr_reg(input logic [7:0] a, input logic [23:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    wdata <= ~d;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken inside it.
  task automatic rd_reg(input logic [7:0] a, output logic [23:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
endmodule
